// ===== dv/jts_checker.sv
// checker for the test access port block
// assumes it is bound to jts_tap and tck runs far slower than clk
module jts_checker (
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire logic                          tck,
  input wire logic                          tms,
  input wire logic                          tdi,
  input wire logic [jts_pkg::BND_WIDTH-1:0] ring_in,
  input wire logic                          tdo,
  input wire logic                          tdo_oe,
  input wire logic [jts_pkg::IR_WIDTH-1:0]  instruction_holder,
  input wire logic                          tap_in_reset,
  input wire logic                          boundary_drive,
  input wire logic                          pins_high_z
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       tq;
  logic [3:0] fc;
  logic [3:0] rc;
  // ==========================================
  // tck edges seen from the pin
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) tq <= 1'b0;
    else tq <= tck;
  // clocks since the last tck fall
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) fc <= 4'hf;
    else if (tq && !tck) fc <= 4'h0;
    else if (fc != 4'hf) fc <= fc + 4'h1;
  // tck rises in a row with tms high
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) rc <= 4'h0;
    else if (!tq && tck) rc <= !tms ? 4'h0 : (rc == 4'hf) ? rc : rc + 4'h1;
  AST_POWER_UP: assert property ($rose(rst_n) |-> tap_in_reset
    && instruction_holder == jts_pkg::INS_IDCODE) else $error("bad state after reset");
  AST_RESET_ID: assert property (tap_in_reset [*8]
    |-> instruction_holder == jts_pkg::INS_IDCODE) else $error("no preload in reset");
  AST_TDO_FALL: assert property ($changed(tdo) || $changed(tdo_oe)
    |-> fc inside {[1:8]}) else $error("tdo moved away from a tck fall");
  AST_IR_UPDATE: assert property ($changed(instruction_holder)
    |-> !tdo_oe && fc inside {[1:8]}) else $error("instruction changed outside update");
  AST_OE_RESET: assert property (tap_in_reset |-> !tdo_oe)
    else $error("tdo driven in reset");
  AST_FIVE_ONES: assert property (rc == 4'h5 |-> ##[0:8] tap_in_reset)
    else $error("five tms ones missed reset");
  AST_EXTEST: assert property ((instruction_holder == jts_pkg::INS_EXTEST) [*3]
    |-> boundary_drive && !pins_high_z) else $error("extest pins wrong");
  AST_HIGHZ: assert property ((instruction_holder == jts_pkg::INS_HIGHZ) [*3]
    |-> pins_high_z && !boundary_drive) else $error("highz pins wrong");
  AST_IDLE_PINS: assert property ((instruction_holder == jts_pkg::INS_IDCODE) [*3]
    |-> !boundary_drive && !pins_high_z) else $error("pins moved under idcode");
endmodule
bind jts_tap jts_checker chk (.*);

// ===== dv/jts_ctrl_model.sv
// behavioural boundary-scan controller driving the test pins
// assumes each step is entered just after a clk rise with tck low
module jts_ctrl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  logic got;
  logic want;
  event smp;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // ==========================================
  // one 800 ns tck period; idle tdi toggles
  task automatic step(input logic s, input logic d, input logic w);
    tms = s;
    tdi = w ? d : ~tdi;
    #400 tck = 1'b1;
    #390 got = tdo;
    want = w;
    ->smp;
    #10 tck = 1'b0;
  endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the test access port
// assumes jts_tap on a 10 MHz clk with the controller model on its pins
module tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  logic                          clk, rst_n, tck, tms, tdi, tdo, tdo_oe, bdrv, hz, in_rst, e;
  logic [jts_pkg::BND_WIDTH-1:0] ring_in;
  logic [7:0]                    ir, c;
  logic [31:0]                   lf;
  logic [127:0]                  d;
  logic                          q[$];
  int                            err_total, compares;
  logic [7:0] codes [7] = '{8'hff, 8'h07, 8'h03, 8'h22, 8'h05, 8'hff, 8'h00};
  jts_ctrl_model m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jts_tap uut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe), .instruction_holder(ir),
    .tap_in_reset(in_rst), .boundary_drive(bdrv), .pins_high_z(hz));
  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic go(input logic [7:0] p, input int n);
    for (int i = 0; i < n; i++) m.step(p[i], 1'b0, 1'b0);
  endtask
  task automatic sh(input logic [127:0] v, input logic [127:0] x, input int n);
    for (int i = 0; i < n; i++) begin
      q.push_back(x[i]);
      m.step(i == n - 1, v[i], 1'b1);
    end
  endtask
  task automatic load(input logic [7:0] k);
    go(8'h03, 4);
    sh(k, jts_pkg::IR_CAPTURE, 8);
    `CHK(ir, c)
    go(8'h01, 2);
    `CHK(ir, k)
    `CHK(tdo_oe, 1'b0)
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial forever begin
    @(m.smp);
    if (m.want) begin
      e = q.pop_front();
      `CHK(m.got, e)
      `CHK(tdo_oe, 1'b1)
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    ring_in = '0;
    lf = 32'hfc395f1b;
    err_total = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK(ir, jts_pkg::INS_IDCODE)
    `CHK(in_rst, 1'b1)
    go(8'h00, 1);
    c = jts_pkg::INS_IDCODE;
    foreach (codes[j]) begin
      for (int k = 0; k < 4; k++) begin
        lf = lfsr(lf);
        d[32*k+:32] = lf;
      end
      load(codes[j]);
      c = codes[j];
      `CHK(bdrv, c == jts_pkg::INS_EXTEST || c == jts_pkg::INS_CLAMP)
      `CHK(hz, c == jts_pkg::INS_HIGHZ)
      // ring must stand before capture-dr
      ring_in = d[jts_pkg::BND_WIDTH-1:0];
      go(8'h01, 3);
      if (c == jts_pkg::INS_SAMPLE || c == jts_pkg::INS_EXTEST) begin
        sh(d, d, jts_pkg::BND_WIDTH);
      end
      else if (c == jts_pkg::INS_IDCODE) sh(d, jts_pkg::ID_CODE_RESET, 32);
      else sh(d, {d[126:0], 1'b0}, 8);
      go(8'h01, 2);
      $display("test code %h done", c);
    end
    go(8'h01, 3);
    go(8'h3f, 6);
    `CHK(in_rst, 1'b1)
    `CHK(ir, jts_pkg::INS_IDCODE)
    $display("test tms reset done");
    conclude();
  end
endmodule

// ===== hdl/jts_pkg.sv
// package of constants for the test access port block
// assumes a 10 MHz system clock sampling the slow test pins
package jts_pkg;
  localparam int IR_WIDTH = 8;
  localparam int ID_WIDTH = 32;
  localparam int BND_WIDTH = 113;
  localparam int RESET_TMS_EDGES = 5;
  localparam int unsigned CLK_MHZ = 10;

  // instruction codes; values are arbitrary, the real table is not given
  localparam logic [7:0] INS_EXTEST = 8'h00;
  localparam logic [7:0] INS_IDCODE = 8'h22;
  localparam logic [7:0] INS_SAMPLE = 8'h05;
  localparam logic [7:0] INS_CLAMP = 8'h07;
  localparam logic [7:0] INS_HIGHZ = 8'h03;
  localparam logic [7:0] INS_BYPASS = 8'hff;
  localparam logic [7:0] IR_CAPTURE = 8'h01;

  // identification value is arbitrary, bit 0 fixed at one
  localparam logic [31:0] ID_CODE_RESET = 32'h0a5a_0001;

  typedef enum logic [3:0] {
    JTS_RESET      = 4'h0,
    JTS_IDLE       = 4'h1,
    JTS_SEL_DR     = 4'h3,
    JTS_CAPT_DR    = 4'h2,
    JTS_SHIFT_DR   = 4'h6,
    JTS_EXIT1_DR   = 4'h7,
    JTS_PAUSE_DR   = 4'h5,
    JTS_EXIT2_DR   = 4'h4,
    JTS_UPD_DR     = 4'hc,
    JTS_SEL_IR     = 4'hd,
    JTS_CAPT_IR    = 4'hf,
    JTS_SHIFT_IR   = 4'he,
    JTS_EXIT1_IR   = 4'ha,
    JTS_PAUSE_IR   = 4'hb,
    JTS_EXIT2_IR   = 4'h9,
    JTS_UPD_IR     = 4'h8
  } jts_state_t;
endpackage

// ===== hdl/jts_sync.sv
// two-flop synchroniser with edge detection for the test pins
// assumes pins asynchronous to clk; first flop read only by second
module jts_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tck_pin,
  input  wire logic tms_pin,
  input  wire logic tdi_pin,
  output logic      tck_rise,
  output logic      tck_fall,
  output logic      tms_s,
  output logic      tdi_s
);
  logic [2:0] meta;
  logic [2:0] sync;
  logic       tck_last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 3'h0;
      sync <= 3'h0;
    end else begin
      meta <= {tck_pin, tms_pin, tdi_pin};
      sync <= meta;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_last <= 1'b0;
      tck_rise <= 1'b0;
      tck_fall <= 1'b0;
      tms_s    <= 1'b1;
      tdi_s    <= 1'b0;
    end else begin
      tck_last <= sync[2];
      tck_rise <= sync[2] & ~tck_last;
      tck_fall <= ~sync[2] & tck_last;
      tms_s    <= sync[1];
      tdi_s    <= sync[0];
    end
  end
endmodule

// ===== hdl/jts_tap.sv
// test access port: state machine, instruction, bypass, id, boundary
// assumes tck well below clk/4; boundary ring values arrive on ring_in
// Operation
// [R1] sample inputs on tck rise, change tdo on tck fall
// [R2] tms steers the tap state machine through the standard states
// [R3] selected serial register follows tap state and loaded instruction
// [R4] five tck rises with tms high always reach test-logic-reset
// [R5] power-up reset forces the state machine into test-logic-reset
// [R6] eight-bit instruction register loads only while it sits in the chain
// [R7] idcode preloaded at power-up and on test-logic-reset
// [R8] one-bit bypass register passes data with one stage of delay
// [R9] bypass instruction loads zero into the bypass register
// [R10] capture-dr under idcode loads the fixed 32-bit identification code
// [R11] identification register shifts out during shift-dr
// [R12] capture-dr under a boundary instruction samples the io ring
// [R13] boundary register shifts in shift-dr; extest and sample select it
// [R14] only a small subset of standard instructions is implemented
// [R15] shifted instruction takes effect only in update-ir
// [R16] controller must not load reserved instruction codes
// [R17] tdo driven only in shift-ir or shift-dr
module jts_tap (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          tck,
  input  wire logic                          tms,
  input  wire logic                          tdi,
  input  wire logic [jts_pkg::BND_WIDTH-1:0] ring_in,
  output logic                               tdo,
  output logic                               tdo_oe,
  output logic [jts_pkg::IR_WIDTH-1:0]       instruction_holder,
  output logic                               tap_in_reset,
  output logic                               boundary_drive,
  output logic                               pins_high_z
);
  jts_pkg::jts_state_t state;
  jts_pkg::jts_state_t next_state;

  logic                           tck_rise;
  logic                           tck_fall;
  logic                           tms_s;
  logic                           tdi_s;
  logic [jts_pkg::IR_WIDTH-1:0]   ir_shift;
  logic                           single_bit_passthrough;
  logic [jts_pkg::ID_WIDTH-1:0]   identification_code;
  logic [jts_pkg::BND_WIDTH-1:0]  bnd_shift;
  logic                           next_tdo;

  jts_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .tck_pin  (tck),
    .tms_pin  (tms),
    .tdi_pin  (tdi),
    .tck_rise (tck_rise),
    .tck_fall (tck_fall),
    .tms_s    (tms_s),
    .tdi_s    (tdi_s)
  );

  // instructions that put the boundary register in the chain
  function automatic logic sel_boundary(input logic [jts_pkg::IR_WIDTH-1:0] ins);
    sel_boundary = (ins == jts_pkg::INS_EXTEST) || (ins == jts_pkg::INS_SAMPLE); // R13
  endfunction

  function automatic logic sel_id(input logic [jts_pkg::IR_WIDTH-1:0] ins);
    sel_id = (ins == jts_pkg::INS_IDCODE);
  endfunction

  // ==========================================================
  // tap state machine
  always_comb begin
    case (state) // R2
      jts_pkg::JTS_RESET:    next_state = tms_s ? jts_pkg::JTS_RESET    : jts_pkg::JTS_IDLE;
      jts_pkg::JTS_IDLE:     next_state = tms_s ? jts_pkg::JTS_SEL_DR   : jts_pkg::JTS_IDLE;
      jts_pkg::JTS_SEL_DR:   next_state = tms_s ? jts_pkg::JTS_SEL_IR   : jts_pkg::JTS_CAPT_DR;
      jts_pkg::JTS_CAPT_DR:  next_state = tms_s ? jts_pkg::JTS_EXIT1_DR : jts_pkg::JTS_SHIFT_DR;
      jts_pkg::JTS_SHIFT_DR: next_state = tms_s ? jts_pkg::JTS_EXIT1_DR : jts_pkg::JTS_SHIFT_DR;
      jts_pkg::JTS_EXIT1_DR: next_state = tms_s ? jts_pkg::JTS_UPD_DR   : jts_pkg::JTS_PAUSE_DR;
      jts_pkg::JTS_PAUSE_DR: next_state = tms_s ? jts_pkg::JTS_EXIT2_DR : jts_pkg::JTS_PAUSE_DR;
      jts_pkg::JTS_EXIT2_DR: next_state = tms_s ? jts_pkg::JTS_UPD_DR   : jts_pkg::JTS_SHIFT_DR;
      jts_pkg::JTS_UPD_DR:   next_state = tms_s ? jts_pkg::JTS_SEL_DR   : jts_pkg::JTS_IDLE;
      // any state reaches reset after at most five tms-high rises
      jts_pkg::JTS_SEL_IR:   next_state = tms_s ? jts_pkg::JTS_RESET    : jts_pkg::JTS_CAPT_IR; // R4
      jts_pkg::JTS_CAPT_IR:  next_state = tms_s ? jts_pkg::JTS_EXIT1_IR : jts_pkg::JTS_SHIFT_IR;
      jts_pkg::JTS_SHIFT_IR: next_state = tms_s ? jts_pkg::JTS_EXIT1_IR : jts_pkg::JTS_SHIFT_IR;
      jts_pkg::JTS_EXIT1_IR: next_state = tms_s ? jts_pkg::JTS_UPD_IR   : jts_pkg::JTS_PAUSE_IR;
      jts_pkg::JTS_PAUSE_IR: next_state = tms_s ? jts_pkg::JTS_EXIT2_IR : jts_pkg::JTS_PAUSE_IR;
      jts_pkg::JTS_EXIT2_IR: next_state = tms_s ? jts_pkg::JTS_UPD_IR   : jts_pkg::JTS_SHIFT_IR;
      jts_pkg::JTS_UPD_IR:   next_state = tms_s ? jts_pkg::JTS_SEL_DR   : jts_pkg::JTS_IDLE;
      default:               next_state = jts_pkg::JTS_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= jts_pkg::JTS_RESET; // R5
    end else if (tck_rise) begin // R1
      state <= next_state;
    end
  end

  // ==========================================================
  // instruction register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift <= jts_pkg::IR_CAPTURE;
    end else if (tck_rise) begin
      case (state)
        jts_pkg::JTS_CAPT_IR:  ir_shift <= jts_pkg::IR_CAPTURE;
        jts_pkg::JTS_SHIFT_IR: ir_shift <= {tdi_s, ir_shift[jts_pkg::IR_WIDTH-1:1]}; // R6
        default:               ir_shift <= ir_shift;
      endcase
    end
  end

  // active instruction changes only in update-ir; reset loads idcode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instruction_holder <= jts_pkg::INS_IDCODE; // R7
    end else if (tck_fall) begin
      if (state == jts_pkg::JTS_RESET) begin
        instruction_holder <= jts_pkg::INS_IDCODE; // R7
      end else if (state == jts_pkg::JTS_UPD_IR) begin
        instruction_holder <= ir_shift; // R15
      end
    end
  end

  // ==========================================================
  // data registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      single_bit_passthrough <= 1'b0;
    end else if (tck_rise) begin
      if (state == jts_pkg::JTS_CAPT_DR) begin
        single_bit_passthrough <= 1'b0; // R9
      end else if (state == jts_pkg::JTS_SHIFT_DR) begin
        single_bit_passthrough <= tdi_s; // R8
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      identification_code <= jts_pkg::ID_CODE_RESET;
    end else if (tck_rise && sel_id(instruction_holder)) begin
      if (state == jts_pkg::JTS_CAPT_DR) begin
        identification_code <= jts_pkg::ID_CODE_RESET; // R10
      end else if (state == jts_pkg::JTS_SHIFT_DR) begin
        identification_code <= {tdi_s, identification_code[jts_pkg::ID_WIDTH-1:1]}; // R11
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bnd_shift <= '0;
    end else if (tck_rise && sel_boundary(instruction_holder)) begin
      if (state == jts_pkg::JTS_CAPT_DR) begin
        bnd_shift <= ring_in; // R12
      end else if (state == jts_pkg::JTS_SHIFT_DR) begin
        bnd_shift <= {tdi_s, bnd_shift[jts_pkg::BND_WIDTH-1:1]}; // R13
      end
    end
  end

  // ==========================================================
  // serial output select; unknown codes fall back to bypass
  always_comb begin
    if (state == jts_pkg::JTS_SHIFT_IR) begin // R3
      next_tdo = ir_shift[0];
    end else if (sel_id(instruction_holder)) begin
      next_tdo = identification_code[0];
    end else if (sel_boundary(instruction_holder)) begin
      next_tdo = bnd_shift[0];
    end else begin
      next_tdo = single_bit_passthrough; // R14
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin // R1
      tdo    <= next_tdo;
      tdo_oe <= (state == jts_pkg::JTS_SHIFT_IR) || (state == jts_pkg::JTS_SHIFT_DR); // R17
    end
  end

  // ==========================================================
  // status levels toward the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_in_reset   <= 1'b1;
      boundary_drive <= 1'b0;
      pins_high_z    <= 1'b0;
    end else begin
      tap_in_reset   <= (state == jts_pkg::JTS_RESET);
      boundary_drive <= (instruction_holder == jts_pkg::INS_EXTEST) ||
                        (instruction_holder == jts_pkg::INS_CLAMP);
      pins_high_z    <= (instruction_holder == jts_pkg::INS_HIGHZ);
    end
  end
endmodule
